// [core/mac_wakeup_and_checksum_ctrl.sv]
`timescale 1ns/10ps
module mac_wakeup_and_checksum_ctrl
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [11:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic [1:0] avs_response_out,
  input wire logic magic_packet_valid_in,
  input wire logic broadcast_valid_in,
  input wire logic station_addr_match_in,
  input wire logic pattern_match_in,
  input wire logic resume_done_in,
  output logic wake_request_out,
  output logic remote_wake_mode_out,
  output logic tx_csum_engine_enable_out,
  output logic rx_csum_engine_enable_out,
  output logic rx_csum_start_mode_out,
  output logic [7:0] rx_csum_fixed_start_out,
  output logic irq_out
);
  // ==========================================================================
  // state
  typedef struct packed
  {
    wake_csum_pkg::bus_state_t bus;
    logic [31:0] rdata;
    logic resp_err;
    logic station_wake;
    logic pattern_wake;
    logic magic_wake;
    logic bcast_wake;
    logic resume_clears;
    logic station_seen;
    logic pattern_seen;
    logic tx_en;
    logic rx_mode;
    logic rx_en;
    logic [3:0] irq_en;
    logic wake_req;
  } state_t;

  state_t st;
  state_t next_st;
  logic magic_flag;
  logic bcast_flag;
  logic [3:0] irq_status;
  logic [3:0] irq_set;
  logic [3:0] irq_clr;
  logic acc;
  logic wr_wake_ctrl;
  logic magic_ev;
  logic bcast_ev;
  logic station_ev;
  logic pattern_ev;
  logic resume_clr;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction

  // ==========================================================================
  // events gated by enables
  assign acc = st.bus == wake_csum_pkg::bus_idle && (avs_read_in || avs_write_in);
  assign wr_wake_ctrl = acc && avs_write_in && avs_byteenable_in[0]
    && hit(avs_address_in, wake_csum_pkg::wakeup_control_status_addr);
  assign magic_ev = magic_packet_valid_in && st.magic_wake;
  assign bcast_ev = broadcast_valid_in && st.bcast_wake;
  assign station_ev = station_addr_match_in && st.station_wake;
  assign pattern_ev = pattern_match_in && st.pattern_wake;
  assign resume_clr = resume_done_in && st.resume_clears;

  // ==========================================================================
  // wakeup flags, write one to clear
  wake_event_latch u_magic
  (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .set_in(magic_ev),
    .clear_in(resume_clr
      || (wr_wake_ctrl && avs_writedata_in[wake_csum_pkg::magic_packet_seen_bit])),
    .flag_out(magic_flag)
  );
  wake_event_latch u_bcast
  (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .set_in(bcast_ev),
    .clear_in(resume_clr
      || (wr_wake_ctrl && avs_writedata_in[wake_csum_pkg::broadcast_seen_bit])),
    .flag_out(bcast_flag)
  );

  // ==========================================================================
  // interrupt status
  assign irq_set = {pattern_ev, station_ev, bcast_ev, magic_ev};
  assign irq_clr = (acc && avs_write_in && avs_byteenable_in[0]
    && hit(avs_address_in, wake_csum_pkg::wake_irq_clear_addr)) ? avs_writedata_in[3:0] : 4'h0;
  genvar gi;
  generate
    for (gi = 0; gi < wake_csum_pkg::irq_width; gi++)
    begin : g_irq
      wake_event_latch u_irq
      (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .set_in(irq_set[gi]),
        .clear_in(irq_clr[gi]),
        .flag_out(irq_status[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // next state
  always_comb
  begin
    next_st = st;
    next_st.wake_req = magic_ev || bcast_ev || station_ev || pattern_ev;
    if (station_ev)
      next_st.station_seen = 1'b1;
    else if (resume_clr || (wr_wake_ctrl && avs_writedata_in[wake_csum_pkg::station_seen_bit]))
      next_st.station_seen = 1'b0;
    if (pattern_ev)
      next_st.pattern_seen = 1'b1;
    else if (resume_clr || (wr_wake_ctrl && avs_writedata_in[wake_csum_pkg::pattern_seen_bit]))
      next_st.pattern_seen = 1'b0;
    case (st.bus)
      wake_csum_pkg::bus_idle:
      begin
        if (acc)
        begin
          next_st.bus = wake_csum_pkg::bus_answer;
          next_st.resp_err = 1'b0;
          next_st.rdata = wake_csum_pkg::zero_word;
          if (hit(avs_address_in, wake_csum_pkg::wakeup_control_status_addr))
          begin
            next_st.rdata[wake_csum_pkg::resume_clears_bit] = st.resume_clears;
            next_st.rdata[wake_csum_pkg::station_seen_bit] = st.station_seen;
            next_st.rdata[wake_csum_pkg::pattern_seen_bit] = st.pattern_seen;
            next_st.rdata[wake_csum_pkg::magic_packet_seen_bit] = magic_flag;
            next_st.rdata[wake_csum_pkg::broadcast_seen_bit] = bcast_flag;
            next_st.rdata[wake_csum_pkg::station_addr_wake_bit] = st.station_wake;
            next_st.rdata[wake_csum_pkg::pattern_frame_wake_bit] = st.pattern_wake;
            next_st.rdata[wake_csum_pkg::magic_wake_bit] = st.magic_wake;
            next_st.rdata[wake_csum_pkg::broadcast_wake_bit] = st.bcast_wake;
            if (avs_write_in && avs_byteenable_in[0])
            begin
              next_st.station_wake = avs_writedata_in[wake_csum_pkg::station_addr_wake_bit];
              next_st.pattern_wake = avs_writedata_in[wake_csum_pkg::pattern_frame_wake_bit];
              next_st.magic_wake = avs_writedata_in[wake_csum_pkg::magic_wake_bit];
              next_st.bcast_wake = avs_writedata_in[wake_csum_pkg::broadcast_wake_bit];
            end
            if (avs_write_in && avs_byteenable_in[1])
              next_st.resume_clears = avs_writedata_in[wake_csum_pkg::resume_clears_bit];
          end
          else if (hit(avs_address_in, wake_csum_pkg::checksum_offload_control_addr))
          begin
            next_st.rdata[wake_csum_pkg::tx_csum_enable_bit] = st.tx_en;
            next_st.rdata[wake_csum_pkg::rx_csum_mode_bit] = st.rx_mode;
            next_st.rdata[wake_csum_pkg::rx_csum_enable_bit] = st.rx_en;
            if (avs_write_in && avs_byteenable_in[2])
              next_st.tx_en = avs_writedata_in[wake_csum_pkg::tx_csum_enable_bit];
            if (avs_write_in && avs_byteenable_in[0])
            begin
              next_st.rx_mode = avs_writedata_in[wake_csum_pkg::rx_csum_mode_bit];
              next_st.rx_en = avs_writedata_in[wake_csum_pkg::rx_csum_enable_bit];
            end
          end
          else if (hit(avs_address_in, wake_csum_pkg::wake_irq_status_addr))
            next_st.rdata[3:0] = irq_status;
          else if (hit(avs_address_in, wake_csum_pkg::wake_irq_enable_addr))
          begin
            next_st.rdata[3:0] = st.irq_en;
            if (avs_write_in && avs_byteenable_in[0])
              next_st.irq_en = avs_writedata_in[3:0];
          end
          else if (!hit(avs_address_in, wake_csum_pkg::wake_irq_clear_addr))
            next_st.resp_err = 1'b1;
        end
      end
      wake_csum_pkg::bus_answer:
      begin
        next_st.bus = wake_csum_pkg::bus_idle;
      end
      default:
      begin
        next_st.bus = wake_csum_pkg::bus_idle;
      end
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      st <= '0;
      st.bus <= wake_csum_pkg::bus_idle;
    end
    else
      st <= next_st;
  end

  // ==========================================================================
  // outputs
  assign avs_waitrequest_out = st.bus != wake_csum_pkg::bus_answer;
  assign avs_readdata_out = st.rdata;
  assign avs_response_out = st.resp_err ? 2'h2 : 2'h0;
  assign wake_request_out = st.wake_req;
  assign remote_wake_mode_out = st.station_wake || st.pattern_wake || st.bcast_wake;
  assign tx_csum_engine_enable_out = st.tx_en;
  assign rx_csum_engine_enable_out = st.rx_en;
  assign rx_csum_start_mode_out = st.rx_mode;
  assign rx_csum_fixed_start_out = wake_csum_pkg::rx_csum_fixed_start;
  assign irq_out = |(irq_status & st.irq_en);

  // ==========================================================================
  // checks
  a_magic_sets_flag: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    magic_ev |=> magic_flag) else $error("magic flag not set");
  a_magic_disabled_quiet: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (!st.magic_wake && !magic_flag && !(acc && avs_write_in)) |=> !magic_flag)
    else $error("magic flag set while disabled");
  a_resume_clears_flags: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (resume_clr && !magic_ev && !bcast_ev) |=> !magic_flag && !bcast_flag)
    else $error("resume did not clear flags");
  a_bcast_sets_flag: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    bcast_ev |=> bcast_flag && wake_request_out) else $error("broadcast flag not set");
  a_station_wake: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (station_addr_match_in && st.station_wake) |=> wake_request_out && st.station_seen)
    else $error("station wake missed");
  a_pattern_wake: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (pattern_match_in && st.pattern_wake) |=> st.pattern_seen) else $error("pattern wake missed");
  a_bcast_enable_mode: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    st.bcast_wake |-> remote_wake_mode_out) else $error("broadcast enable without wake mode");
  a_tx_enable_write: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (acc && avs_write_in && avs_byteenable_in[2]
      && avs_address_in == wake_csum_pkg::checksum_offload_control_addr)
    |=> tx_csum_engine_enable_out == $past(avs_writedata_in[16]))
    else $error("tx engine enable not written");
  a_rx_enable_write: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (acc && avs_write_in && avs_byteenable_in[0]
      && avs_address_in == wake_csum_pkg::checksum_offload_control_addr)
    |=> rx_csum_engine_enable_out == $past(avs_writedata_in[0])
      && rx_csum_start_mode_out == $past(avs_writedata_in[1]))
    else $error("rx controls not written");
  a_reserved_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (!avs_waitrequest_out) |-> avs_readdata_out[31:17] == 15'h0000)
    else $error("reserved bits not zero");
  a_irq_raised: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (magic_ev && st.irq_en[wake_csum_pkg::irq_magic_bit] && !(acc && avs_write_in)) |=> irq_out)
    else $error("interrupt not raised by magic event");
  a_resume_clears_seen: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (resume_clr && !station_ev && !pattern_ev) |=> !st.station_seen && !st.pattern_seen)
    else $error("resume did not clear match flags");
  a_bcast_write_clear: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (wr_wake_ctrl && avs_writedata_in[wake_csum_pkg::broadcast_seen_bit] && !bcast_ev)
    |=> !bcast_flag) else $error("broadcast flag not cleared by write");
  a_station_en_write: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    wr_wake_ctrl
    |=> st.station_wake == $past(avs_writedata_in[wake_csum_pkg::station_addr_wake_bit]))
    else $error("station wake enable not written");
  a_pattern_en_write: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    wr_wake_ctrl
    |=> st.pattern_wake == $past(avs_writedata_in[wake_csum_pkg::pattern_frame_wake_bit]))
    else $error("pattern wake enable not written");
  a_magic_en_write: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    wr_wake_ctrl
    |=> st.magic_wake == $past(avs_writedata_in[wake_csum_pkg::magic_wake_bit]))
    else $error("magic wake enable not written");
  a_broadcast_wake_enable_write: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    wr_wake_ctrl
    |=> st.bcast_wake == $past(avs_writedata_in[wake_csum_pkg::broadcast_wake_bit]))
    else $error("broadcast wake enable not written");
  a_magic_no_wake: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (magic_packet_valid_in && !st.magic_wake && !bcast_ev && !station_ev && !pattern_ev)
    |=> !wake_request_out) else $error("wake request while magic disabled");
  a_reset_levels: assert property (@(posedge clock_in)
    !rst_n_in |=> !tx_csum_engine_enable_out && !rx_csum_engine_enable_out
      && !rx_csum_start_mode_out) else $error("checksum controls not reset");
  a_irq_clear: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (irq_clr[wake_csum_pkg::irq_magic_bit] && !magic_ev)
    |=> !irq_status[wake_csum_pkg::irq_magic_bit])
    else $error("interrupt status not cleared");
  a_wait_one_cycle: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !avs_waitrequest_out |=> avs_waitrequest_out) else $error("waitrequest low too long");
endmodule // mac_wakeup_and_checksum_ctrl

// [core/wake_csum_pkg.sv]
package wake_csum_pkg;
  // ==========================================================================
  // register byte addresses
  localparam logic [11:0] wakeup_control_status_addr = 12'h12c;
  localparam logic [11:0] checksum_offload_control_addr = 12'h130;
  localparam logic [11:0] wake_irq_status_addr = 12'h134;
  localparam logic [11:0] wake_irq_clear_addr = 12'h138;
  localparam logic [11:0] wake_irq_enable_addr = 12'h13c;
  // ==========================================================================
  // wakeup_control_status fields
  localparam int magic_packet_seen_bit = 5;
  localparam int broadcast_seen_bit = 4;
  localparam int station_addr_wake_bit = 3;
  localparam int pattern_frame_wake_bit = 2;
  localparam int magic_wake_bit = 1;
  localparam int broadcast_wake_bit = 0;
  localparam int resume_clears_bit = 8;
  localparam int station_seen_bit = 7;
  localparam int pattern_seen_bit = 6;
  // ==========================================================================
  // checksum_offload_control fields
  localparam int tx_csum_enable_bit = 16;
  localparam int rx_csum_mode_bit = 1;
  localparam int rx_csum_enable_bit = 0;
  // ==========================================================================
  // event bits in the interrupt registers
  localparam int irq_magic_bit = 0;
  localparam int irq_broadcast_bit = 1;
  localparam int irq_station_bit = 2;
  localparam int irq_pattern_bit = 3;
  localparam int irq_width = 4;
  // ==========================================================================
  // checksum start offsets in bytes
  localparam logic [7:0] rx_csum_fixed_start = 8'h0e;
  // ==========================================================================
  // reset values
  localparam logic [31:0] zero_word = 32'h0000_0000;
  localparam logic [3:0] irq_reset = 4'h0;
  // ==========================================================================
  // bus slave states
  typedef enum logic [1:0]
  {
    bus_idle = 2'b01,
    bus_answer = 2'b10
  } bus_state_t;
endpackage

// [core/wake_event_latch.sv]
`timescale 1ns/10ps
// ==========================================================================
// sticky event bit: set wins over clear
module wake_event_latch
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic set_in,
  input wire logic clear_in,
  output logic flag_out
);
  logic flag;
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      flag <= 1'b0;
    else if (set_in)
      flag <= 1'b1;
    else if (clear_in)
      flag <= 1'b0;
  end
  assign flag_out = flag;
endmodule // wake_event_latch

// [sim/tb.sv]
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
  $display("BAD %s exp %h seen %h", nm, exp, got); end end
module tb;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [11:0] avs_address_in = 12'h000;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0000_0000;
  logic [3:0] avs_byteenable_in = 4'hf;
  logic [4:0] ev = 5'h00;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [1:0] avs_response_out;
  logic wake_request_out, remote_wake_mode_out, irq_out;
  logic tx_out, rx_en_out, mode_out;
  logic [7:0] fixed_start;
  logic [31:0] q;
  int err_count = 0;
  int samples_checked = 0;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] q; logic [3:0] o;} row_t;
  row_t rows [12];
  always #25 clock_in = ~clock_in;
  // ==========================================================================
  // design under test
  mac_wakeup_and_checksum_ctrl i_mac_wakeup_and_checksum_ctrl
  (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .avs_response_out(avs_response_out), .magic_packet_valid_in(ev[0]),
    .broadcast_valid_in(ev[1]), .station_addr_match_in(ev[2]), .pattern_match_in(ev[3]),
    .resume_done_in(ev[4]), .wake_request_out(wake_request_out),
    .remote_wake_mode_out(remote_wake_mode_out), .tx_csum_engine_enable_out(tx_out),
    .rx_csum_engine_enable_out(rx_en_out), .rx_csum_start_mode_out(mode_out),
    .rx_csum_fixed_start_out(fixed_start), .irq_out(irq_out)
  );
  // ==========================================================================
  // bus master and helpers
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] be, input logic [1:0] er, output logic [31:0] rd_q);
    @(posedge clock_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    do
    begin
      @(posedge clock_in);
    end
    while (avs_waitrequest_out !== 1'b0);
    rd_q = avs_readdata_out;
    `CHK("response", er, avs_response_out)
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, 4'hf, 2'b00, x);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, 4'hf, 2'b00, x);
    `CHK("readdata", e, x)
  endtask
  task automatic pulse(input int i, input logic w);
    @(posedge clock_in);
    ev[i] <= 1'b1;
    @(posedge clock_in);
    ev <= 5'h00;
    #1;
    `CHK("wake_request", w, wake_request_out)
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================================================
  // watchdog
  initial
  begin
    repeat (5000) @(posedge clock_in);
    err_count++;
    wrap_up();
  end
  // ==========================================================================
  // main sequence
  initial
  begin
    rows = '{
      '{12'h12c, 32'hffff_ffff, 32'h0000_010f, 4'b0001},
      '{12'h130, 32'h0001_0002, 32'h0001_0002, 4'b1011},
      '{12'h130, 32'hffff_ffff, 32'h0001_0003, 4'b1111},
      '{12'h12c, 32'h0000_0008, 32'h0000_0008, 4'b1111},
      '{12'h12c, 32'h0000_0002, 32'h0000_0002, 4'b1110},
      '{12'h130, 32'h0000_0001, 32'h0000_0001, 4'b0100},
      '{12'h13c, 32'hffff_ffff, 32'h0000_000f, 4'b0100},
      '{12'h13c, 32'h0000_0000, 32'h0000_0000, 4'b0100},
      '{12'h12c, 32'h0000_0004, 32'h0000_0004, 4'b0101},
      '{12'h12c, 32'h0000_0001, 32'h0000_0001, 4'b0101},
      '{12'h12c, 32'h0000_0000, 32'h0000_0000, 4'b0100},
      '{12'h130, 32'h0000_0000, 32'h0000_0000, 4'b0000}};
    repeat (6) @(posedge clock_in);
    rst_n_in <= 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].q);
      `CHK("levels", rows[i].o, {tx_out, rx_en_out, mode_out, remote_wake_mode_out})
    end
    wr(12'h13c, 32'h0000_000f);
    pulse(0, 1'b0);
    rd(12'h12c, 32'h0000_0000);
    wr(12'h12c, 32'h0000_010f);
    pulse(0, 1'b1);
    pulse(1, 1'b1);
    pulse(2, 1'b1);
    pulse(3, 1'b1);
    rd(12'h12c, 32'h0000_01ff);
    rd(12'h134, 32'h0000_000f);
    `CHK("irq", 1'b1, irq_out)
    wr(12'h13c, 32'h0000_0000);
    `CHK("irq", 1'b0, irq_out)
    wr(12'h13c, 32'h0000_0001);
    `CHK("irq", 1'b1, irq_out)
    wr(12'h138, 32'h0000_0001);
    wr(12'h134, 32'h0000_0000);
    rd(12'h134, 32'h0000_000e);
    `CHK("irq", 1'b0, irq_out)
    wr(12'h12c, 32'h0000_013f);
    rd(12'h12c, 32'h0000_01cf);
    pulse(4, 1'b0);
    rd(12'h12c, 32'h0000_010f);
    wr(12'h12c, 32'h0000_000f);
    pulse(1, 1'b1);
    pulse(4, 1'b0);
    rd(12'h12c, 32'h0000_001f);
    bus(1'b0, 12'h200, 32'h0000_0000, 4'hf, 2'b10, q);
    `CHK("unmapped", 32'h0000_0000, q)
    bus(1'b1, 12'h200, 32'hffff_ffff, 4'hf, 2'b10, q);
    bus(1'b1, 12'h130, 32'hffff_ffff, 4'b0100, 2'b00, q);
    rd(12'h130, 32'h0001_0000);
    @(posedge clock_in);
    rst_n_in <= 1'b0;
    repeat (6) @(posedge clock_in);
    rst_n_in <= 1'b1;
    #1;
    `CHK("waitrequest", 1'b1, avs_waitrequest_out)
    `CHK("levels", 5'h00, {tx_out, rx_en_out, mode_out, remote_wake_mode_out, irq_out})
    `CHK("start", 8'h0e, fixed_start)
    rd(12'h12c, 32'h0000_0000);
    rd(12'h130, 32'h0000_0000);
    rd(12'h134, 32'h0000_0000);
    rd(12'h13c, 32'h0000_0000);
    wrap_up();
  end
endmodule // tb
